// >>> include/adc_cfg_pkg.sv
/*
 Constants, codes and carrier types for the converter's pin-routing, engine-sync and decimator-gain register group.
 Assumes one processing clock and a byte-wide register port; offsets are page-0 byte addresses.
*/
package adc_cfg_pkg;

  // Register offsets
  localparam logic [7:0] OFS_RSVD_A_LO = 8'h30;
  localparam logic [7:0] OFS_RSVD_A_HI = 8'h34;
  localparam logic [7:0] OFS_PIN_CTRL = 8'h35;
  localparam logic [7:0] OFS_RSVD_B_LO = 8'h36;
  localparam logic [7:0] OFS_RSVD_B_HI = 8'h38;
  localparam logic [7:0] OFS_SYNC_WIN = 8'h39;
  localparam logic [7:0] OFS_SYNC_TGT = 8'h3A;
  localparam logic [7:0] OFS_DEC_GAIN = 8'h3B;
  localparam logic [7:0] OFS_RSVD_ONE = 8'h3C;

  // Reset values and the reserved read value
  localparam logic [7:0] RST_PIN_CTRL = 8'h12;
  localparam logic [7:0] RST_SYNC_WIN = 8'h00;
  localparam logic [7:0] RST_SYNC_TGT = 8'h00;
  localparam logic [7:0] RST_DEC_GAIN = 8'h44;
  localparam logic [7:0] RST_RSVD_ONE = 8'h00;
  localparam logic [7:0] RSVD_READ = 8'h00;

  // Field positions
  localparam int PIN_KEEPER_BIT = 4;
  localparam int PIN_FUNC_MSB = 3;
  localparam int PIN_FUNC_LSB = 1;
  localparam int PIN_LEVEL_BIT = 0;
  localparam int PIN_WR_MSB = 4;
  localparam int SYNC_MODE_BIT = 7;
  localparam int SYNC_WIN_MSB = 6;
  localparam int GAIN_LEFT_LSB = 4;
  localparam int GAIN_RIGHT_LSB = 0;

  // Decimator gain figures
  localparam logic [7:0] UNITY_OSR = 8'h40;
  localparam logic [4:0] MODE_FIXED_LO = 5'h01;
  localparam logic [4:0] MODE_FIXED_HI = 5'h06;
  localparam logic [4:0] MODE_PROGRAMMABLE = 5'h00;
  localparam logic [3:0] GAIN_CODE_MAX = 4'hC;
  localparam logic [3:0] GAIN_CODE_AUTO = 4'hF;
  localparam logic [3:0] GAIN_CODE_UNITY = 4'h4;
  localparam int GAIN_FRAC_BITS = 24;
  localparam int GAIN_W = 48;

  typedef enum logic [2:0] {
    PIN_OFF = 3'h0,
    PIN_PRIMARY = 3'h1,
    PIN_GPO = 3'h2,
    PIN_DIV_CLK = 3'h3,
    PIN_IRQ_ONE = 3'h4,
    PIN_IRQ_TWO = 3'h5,
    PIN_BCLK2 = 3'h6,
    PIN_WCLK2 = 3'h7
  } pin_func_e;

  typedef struct packed {
    logic fixed_unity;
    logic [7:0] ratio;
    logic [3:0] code;
  } cic_cfg_s;

  typedef struct packed {
    logic [GAIN_W-1:0] gain_fx;
    logic [4:0] applied_code;
    logic code_ok;
  } cic_gain_s;

endpackage

// >>> hw/cic_gain_calc.sv
/*
 One channel's decimator gain: fixed-point gain (24 fraction bits) and the code really applied.
 Assumes the ratio of oversampling to engine decimation is prepared and registered by the caller.
*/
module cic_gain_calc
  import adc_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire cic_cfg_s cfg,
  output cic_gain_s res_q
);

  function automatic logic [5:0] ceil_log2(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 33; i++) begin
      if ((33'h1 << i) < {1'b0, v}) begin
        n = 6'(i + 1);
      end
    end
    return n;
  endfunction

  logic [31:0] r4;
  logic [5:0] lg;
  logic [4:0] code_eff;
  logic ok;
  logic [GAIN_W-1:0] base;
  cic_gain_s res_d;

  always_comb begin
    r4 = 32'(cfg.ratio) * 32'(cfg.ratio) * 32'(cfg.ratio) * 32'(cfg.ratio);
    lg = ceil_log2(r4);
    ok = 1'b1;
    code_eff = {1'b0, cfg.code};
    if (cfg.fixed_unity) begin
      base = GAIN_W'(1) << (GAIN_FRAC_BITS - 4);
    end else begin
      base = GAIN_W'(r4);
    end
    if (cfg.code == GAIN_CODE_AUTO) begin
      if (cfg.fixed_unity) begin
        code_eff = {1'b0, GAIN_CODE_UNITY};
      end else if (lg > 6'(GAIN_FRAC_BITS)) begin
        code_eff = 5'h00;
      end else begin
        code_eff = 5'(6'(GAIN_FRAC_BITS) - lg);
      end
    end else if (cfg.code > GAIN_CODE_MAX) begin
      // Codes 13 and 14 carry no defined gain
      ok = 1'b0;
    end
    res_d.applied_code = code_eff;
    res_d.code_ok = ok;
    // Ratio to the fourth (two to the 20 when fixed_unity) times two to the code
    res_d.gain_fx = ok ? (base << code_eff) : '0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

endmodule // cic_gain_calc

// >>> hw/adc_cfg_regs.sv
/*
 Register group for output-pin routing, engine synchronization and decimator gain, with the pin multiplexer.
 Assumes the control-bus engine presents byte reads and writes as one-cycle strobes on the processing clock,
 and that all routed pin sources come from logic on the same clock.
*/
module adc_cfg_regs
  import adc_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic PRIMARY_SERIAL_DATA,
  input wire logic DIVIDED_CLOCK_OUTPUT,
  input wire logic IRQ_LINE_ONE,
  input wire logic IRQ_LINE_TWO,
  input wire logic SECONDARY_BIT_CLOCK,
  input wire logic SECONDARY_WORD_CLOCK,
  input wire logic [7:0] CONVERTER_OVERSAMPLING_RATIO,
  input wire logic [7:0] ENGINE_DECIMATION,
  input wire logic [4:0] FILTER_MODE,
  output logic DATA_PIN_O,
  output logic DATA_PIN_OE_N,
  output logic DATA_PIN_BUF_PWR,
  output logic DATA_PIN_KEEPER_EN,
  output logic PROGRAMMABLE_MODE,
  output logic CUSTOM_SYNC,
  output logic [7:0] SYNC_WINDOW,
  output logic [8:0] SYNC_TARGET,
  output cic_gain_s LEFT_CIC,
  output cic_gain_s RIGHT_CIC
);

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
    return wr && (a == ofs);
  endfunction

  logic [7:0] pin_ctrl_q;
  logic [7:0] sync_win_q;
  logic [7:0] sync_tgt_q;
  logic [7:0] dec_gain_q;
  logic [7:0] rsvd_one_q;
  logic [7:0] rdata_d;
  pin_func_e pin_func;
  logic pin_o_d;
  logic fixed_unity_q;
  logic [7:0] ratio_q;
  cic_cfg_s left_cfg;
  cic_cfg_s right_cfg;

  // Keeper, function and level fields writable
  // Upper three bits stay at reset value
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_ctrl_q <= RST_PIN_CTRL;
    end else if (wr_hit(REG_WR, REG_ADDR, OFS_PIN_CTRL)) begin
      pin_ctrl_q[PIN_WR_MSB:0] <= REG_WDATA[PIN_WR_MSB:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_win_q <= RST_SYNC_WIN;
    end else if (wr_hit(REG_WR, REG_ADDR, OFS_SYNC_WIN)) begin
      sync_win_q <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_tgt_q <= RST_SYNC_TGT;
    end else if (wr_hit(REG_WR, REG_ADDR, OFS_SYNC_TGT)) begin
      sync_tgt_q <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dec_gain_q <= RST_DEC_GAIN;
    end else if (wr_hit(REG_WR, REG_ADDR, OFS_DEC_GAIN)) begin
      dec_gain_q <= REG_WDATA;
    end
  end

  // Plain storage, no effect on the block
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rsvd_one_q <= RST_RSVD_ONE;
    end else if (wr_hit(REG_WR, REG_ADDR, OFS_RSVD_ONE)) begin
      rsvd_one_q <= REG_WDATA;
    end
  end

  // Reserved blocks ignore writes, read as zero
  always_comb begin
    rdata_d = RSVD_READ;
    if (REG_ADDR == OFS_PIN_CTRL) begin
      rdata_d = pin_ctrl_q;
    end else if (REG_ADDR == OFS_SYNC_WIN) begin
      rdata_d = sync_win_q;
    end else if (REG_ADDR == OFS_SYNC_TGT) begin
      rdata_d = sync_tgt_q;
    end else if (REG_ADDR == OFS_DEC_GAIN) begin
      rdata_d = dec_gain_q;
    end else if (REG_ADDR == OFS_RSVD_ONE) begin
      rdata_d = rsvd_one_q;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_d;
      end
    end
  end

  always_comb begin
    pin_func = pin_func_e'(pin_ctrl_q[PIN_FUNC_MSB:PIN_FUNC_LSB]);
    unique case (pin_func)
      PIN_OFF: pin_o_d = 1'b0;
      PIN_PRIMARY: pin_o_d = PRIMARY_SERIAL_DATA;
      PIN_GPO: pin_o_d = pin_ctrl_q[PIN_LEVEL_BIT];
      PIN_DIV_CLK: pin_o_d = DIVIDED_CLOCK_OUTPUT;
      PIN_IRQ_ONE: pin_o_d = IRQ_LINE_ONE;
      PIN_IRQ_TWO: pin_o_d = IRQ_LINE_TWO;
      PIN_BCLK2: pin_o_d = SECONDARY_BIT_CLOCK;
      PIN_WCLK2: pin_o_d = SECONDARY_WORD_CLOCK;
    endcase
  end

  // One register stage delays routed clocks by a cycle; accepted for timing
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      DATA_PIN_O <= 1'b0;
      DATA_PIN_OE_N <= 1'b0;
      DATA_PIN_BUF_PWR <= 1'b1;
      DATA_PIN_KEEPER_EN <= 1'b0;
    end else begin
      DATA_PIN_O <= pin_o_d;
      DATA_PIN_OE_N <= (pin_func == PIN_OFF);
      DATA_PIN_BUF_PWR <= (pin_func != PIN_OFF);
      // Keeper on when bit is zero
      DATA_PIN_KEEPER_EN <= ~pin_ctrl_q[PIN_KEEPER_BIT];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CUSTOM_SYNC <= 1'b0;
      SYNC_WINDOW <= 8'h00;
      SYNC_TARGET <= 9'h000;
    end else begin
      CUSTOM_SYNC <= sync_win_q[SYNC_MODE_BIT];
      SYNC_WINDOW <= {sync_win_q[SYNC_WIN_MSB:0], 1'b0};
      SYNC_TARGET <= {sync_tgt_q, 1'b0};
    end
  end

  // Divider shared by both channels; ratio registered to keep it off the gain path
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fixed_unity_q <= 1'b0;
      ratio_q <= 8'h00;
      PROGRAMMABLE_MODE <= 1'b0;
    end else begin
      fixed_unity_q <= (CONVERTER_OVERSAMPLING_RATIO == UNITY_OSR) &&
                       (FILTER_MODE >= MODE_FIXED_LO) && (FILTER_MODE <= MODE_FIXED_HI);
      ratio_q <= (ENGINE_DECIMATION == 8'h00) ? 8'h00 : CONVERTER_OVERSAMPLING_RATIO / ENGINE_DECIMATION;
      PROGRAMMABLE_MODE <= (FILTER_MODE == MODE_PROGRAMMABLE);
    end
  end

  always_comb begin
    left_cfg.fixed_unity = fixed_unity_q;
    left_cfg.ratio = ratio_q;
    left_cfg.code = dec_gain_q[GAIN_LEFT_LSB +: 4];
    right_cfg.fixed_unity = fixed_unity_q;
    right_cfg.ratio = ratio_q;
    right_cfg.code = dec_gain_q[GAIN_RIGHT_LSB +: 4];
  end

  cic_gain_calc u_left (
    .clk(CLK),
    .rst_b(RST_B),
    .cfg(left_cfg),
    .res_q(LEFT_CIC)
  );

  cic_gain_calc u_right (
    .clk(CLK),
    .rst_b(RST_B),
    .cfg(right_cfg),
    .res_q(RIGHT_CIC)
  );

endmodule // adc_cfg_regs

// >>> tb/host_model.sv
/*
 Host side of the byte register port: write and read tasks.
 Assumes strobes sampled on the rising edge, read answer one cycle later.
*/
module host_model
  import adc_cfg_pkg::*;
(
  input wire logic clk,
  output logic [7:0] addr,
  output logic wr,
  output logic [7:0] wdata,
  output logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    if ((a >= OFS_RSVD_A_LO && a <= OFS_RSVD_A_HI) || (a >= OFS_RSVD_B_LO && a <= OFS_RSVD_B_HI) ||
        a == OFS_RSVD_ONE) return;
    @(posedge clk);
    addr <= a;
    wdata <= (a == OFS_PIN_CTRL) ? {3'h0, d[4:0]} : d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Stale data would hide a missed strobe
    wdata <= ~wdata;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    v = rvalid;
  endtask
endmodule // host_model

// >>> tb/adc_cfg_regs_sva.sv
/*
 Port checker for the register group.
 Assumes one clock and an asynchronous active-low reset.
*/
module adc_cfg_regs_sva
  import adc_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic DATA_PIN_O,
  input wire logic DATA_PIN_OE_N,
  input wire logic DATA_PIN_BUF_PWR,
  input wire logic DATA_PIN_KEEPER_EN,
  input wire logic [4:0] FILTER_MODE,
  input wire logic PROGRAMMABLE_MODE,
  input wire logic CUSTOM_SYNC,
  input wire logic [7:0] SYNC_WINDOW,
  input wire logic [8:0] SYNC_TARGET
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence s_pin_wr;
    REG_WR && REG_ADDR == OFS_PIN_CTRL;
  endsequence
  sequence s_win_wr;
    REG_WR && REG_ADDR == OFS_SYNC_WIN;
  endsequence
  a_keeper_wr: assert property (s_pin_wr |-> ##2 DATA_PIN_KEEPER_EN == !$past(REG_WDATA[4], 2))
    else $error("keeper enable wrong");
  a_off_wr: assert property (s_pin_wr ##0 REG_WDATA[3:1] == 3'h0 |-> ##2 DATA_PIN_OE_N && !DATA_PIN_BUF_PWR)
    else $error("pin not disabled");
  a_pin_off: assert property (DATA_PIN_OE_N |-> !DATA_PIN_BUF_PWR && !DATA_PIN_O)
    else $error("released pin still powered");
  a_gpo_level: assert property (s_pin_wr ##0 REG_WDATA[3:1] == 3'h2 |-> ##2 DATA_PIN_O == $past(REG_WDATA[0], 2))
    else $error("output level wrong");
  a_win_wr: assert property (s_win_wr |-> ##2 SYNC_WINDOW == {$past(REG_WDATA[6:0], 2), 1'b0} &&
    CUSTOM_SYNC == $past(REG_WDATA[7], 2)) else $error("sync window wrong");
  a_tgt_wr: assert property (REG_WR && REG_ADDR == OFS_SYNC_TGT |-> ##2 SYNC_TARGET == {$past(REG_WDATA, 2), 1'b0})
    else $error("sync target wrong");
  a_prog_mode: assert property ($past(RST_B) |-> PROGRAMMABLE_MODE == ($past(FILTER_MODE) == MODE_PROGRAMMABLE))
    else $error("mode flag wrong");
  a_rsvd_read: assert property (REG_RD && REG_ADDR inside {[OFS_RSVD_A_LO:OFS_RSVD_A_HI]} |=> REG_RDATA == 8'h00)
    else $error("reserved read nonzero");
endmodule // adc_cfg_regs_sva
bind adc_cfg_regs adc_cfg_regs_sva u_sva (.CLK, .RST_B, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
  .DATA_PIN_O, .DATA_PIN_OE_N, .DATA_PIN_BUF_PWR, .DATA_PIN_KEEPER_EN, .FILTER_MODE, .PROGRAMMABLE_MODE,
  .CUSTOM_SYNC, .SYNC_WINDOW, .SYNC_TARGET);

// >>> tb/tb_top.sv
/*
 Self-checking bench for the register group.
 Assumes the host model drives the register port; pin sources come from the bench.
*/
module tb_top
  import adc_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr, wdata, rdata, osr, dec, win;
  logic wr, rd, rvalid, pin_o, oe_n, pwr, keep, prog, csync;
  logic [5:0] src;
  logic [4:0] mode;
  logic [8:0] tgt;
  cic_gain_s lc, rc;
  int error_cnt = 0;
  int num_checks = 0;
  always #20 clk = ~clk;
  host_model u_host (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd), .rdata(rdata), .rvalid(rvalid));
  adc_cfg_regs dut (.CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .PRIMARY_SERIAL_DATA(src[0]), .DIVIDED_CLOCK_OUTPUT(src[1]),
    .IRQ_LINE_ONE(src[2]), .IRQ_LINE_TWO(src[3]), .SECONDARY_BIT_CLOCK(src[4]), .SECONDARY_WORD_CLOCK(src[5]),
    .CONVERTER_OVERSAMPLING_RATIO(osr), .ENGINE_DECIMATION(dec), .FILTER_MODE(mode), .DATA_PIN_O(pin_o),
    .DATA_PIN_OE_N(oe_n), .DATA_PIN_BUF_PWR(pwr), .DATA_PIN_KEEPER_EN(keep), .PROGRAMMABLE_MODE(prog),
    .CUSTOM_SYNC(csync), .SYNC_WINDOW(win), .SYNC_TARGET(tgt), .LEFT_CIC(lc), .RIGHT_CIC(rc));
  task chk(input string n, input logic [53:0] got, input logic [53:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_host.rd_reg(a, d, v);
    chk("rvalid", v, 1'b1);
    chk("rdata", d, e);
  endtask
  task t_reset;
    settle(3);
    chk("keeper", keep, 1'b0);
    rd_chk(OFS_PIN_CTRL, 8'h12);
    rd_chk(OFS_SYNC_WIN, 8'h00);
    rd_chk(OFS_SYNC_TGT, 8'h00);
    rd_chk(OFS_DEC_GAIN, 8'h44);
    rd_chk(OFS_RSVD_A_LO, 8'h00);
    rd_chk(OFS_RSVD_ONE, RST_RSVD_ONE);
    rd_chk(8'hFF, 8'h00);
    chk("left", lc, {48'h1000000, 5'h04, 1'b1});
  endtask
  task t_pin;
    logic e;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 8; c++) begin
        u_host.wr_reg(OFS_PIN_CTRL, {3'h0, c[0], c[2:0], p[0]});
        src <= p[0] ? 6'h2A : 6'h15;
        settle(3);
        case (c)
          0: e = 1'b0;
          1: e = src[0];
          2: e = p[0];
          default: e = src[c-2];
        endcase
        chk("pin", pin_o, e);
        chk("oe_n", oe_n, c == 0);
        chk("power", pwr, c != 0);
        chk("keeper", keep, !c[0]);
      end
    end
  endtask
  task t_sync;
    u_host.wr_reg(OFS_SYNC_WIN, 8'hFF);
    u_host.wr_reg(OFS_SYNC_TGT, 8'hFF);
    settle(3);
    chk("custom", csync, 1'b1);
    chk("window", win, 8'hFE);
    chk("target", tgt, 9'h1FE);
    rd_chk(OFS_SYNC_WIN, 8'hFF);
    u_host.wr_reg(OFS_SYNC_WIN, 8'h01);
    settle(3);
    chk("custom", csync, 1'b0);
    chk("window", win, 8'h02);
  endtask
  task gcase(input logic [7:0] o, input logic [7:0] d, input logic [4:0] m, input logic [7:0] g,
             input logic [53:0] el, input logic [53:0] er);
    @(posedge clk);
    osr <= o;
    dec <= d;
    mode <= m;
    u_host.wr_reg(OFS_DEC_GAIN, g);
    settle(4);
    chk("prog", prog, m == 5'h00);
    chk("left", lc, el);
    chk("right", rc, er);
    rd_chk(OFS_DEC_GAIN, g);
  endtask
  initial begin
    src = 6'h00;
    osr = 8'h40;
    dec = 8'h02;
    mode = 5'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_pin;
    t_sync;
    // Codes keep gain at most one
    // Codes 13 and 14 never sent
    gcase(8'h40, 8'h02, 5'h00, 8'h04, {48'h100000, 5'h0, 1'b1}, {48'h1000000, 5'h4, 1'b1});
    gcase(8'h40, 8'h02, 5'h00, 8'hF4, {48'h1000000, 5'h4, 1'b1}, {48'h1000000, 5'h4, 1'b1});
    gcase(8'h40, 8'h01, 5'h03, 8'h43, {48'h1000000, 5'h4, 1'b1}, {48'h800000, 5'h3, 1'b1});
    end_of_test;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end
endmodule // tb_top
